// File: hw/pdc_printer_dma.v
// How it works
// RQ1: by default only activate commands addressed to channel 5 are answered
// RQ2: activate word 1 bits 13-15 are compared with the channel; match accepts
// RQ3: on acceptance four list words are read from the list address, then stop
// RQ4: list word 1 is the data address, incremented once per data word
// RQ5: list word 2 is a binary count, bit 15 lsb; zero is never supplied
// RQ6: list word 3 bit 2 set chains to a new list at list word 4
// RQ7: without chaining list word 4 is still read but then discarded
// RQ8: activate during a running list stores status with busy bit 12
// RQ9: printer not ready sets status bit 14
// RQ10: bit 15 marks completion or abort, only after the last chained list
// RQ11: status bits 0-11 and 13 are always stored as zero
// RQ12: one word holds two characters, each sent only on printer demand
// RQ13: first character bits 1-7, second bits 9-15; bits 0 and 8 unsent
// RQ14: odd count sends only the first character of the last word
// RQ15: characters go to the printer untranslated
// RQ16: status goes to the channel's reserved pair, 98 plus twice the channel
// RQ17: the status word is written at the even address of the pair
// RQ18: interrupts allowed: raise a request, store only after acknowledge
// RQ19: with interrupts not allowed, store status at once
// RQ20: a status store wins the memory port over list and data reads
// RQ21: the host acknowledges only after arming and store-status-block
`timescale 1ns/10ps
`include "pdc_defs.vh"

module pdc_printer_dma
#(
   parameter [2:0] CHAN_ADDR = `PDC_DEF_CHAN
)
(
   // clock and reset
   input  wire        clk_i,
   input  wire        nrst_i,
   // activate command, both words offered with a one-cycle strobe
   input  wire        act_stb_i,
   input  wire [15:0] act_word1_i,
   input  wire [15:0] act_word2_i,
   // interrupt handshake
   input  wire        interrupt_allow_n_i,
   input  wire        iack_i,
   output wire        irq_o,
   // memory access port
   output wire        mem_req_o,
   output wire        mem_we_o,
   output wire [15:0] mem_addr_o,
   output wire [15:0] mem_wdata_o,
   input  wire        mem_gnt_i,
   input  wire [15:0] mem_rdata_i,
   // line printer
   input  wire        prn_ready_i,
   input  wire        prn_demand_i,
   output wire [6:0]  prn_data_o,
   output wire        prn_strobe_o,
   // controller state
   output wire        busy_o
);

   // the status store runs beside the sequencer, not as one of its states
   // main sequencer states
   localparam [1:0] ST_IDLE = 2'h0;
   localparam [1:0] ST_LIST = 2'h1;
   localparam [1:0] ST_READ = 2'h2;
   localparam [1:0] ST_SEND = 2'h3;

   reg  [1:0]  state_ff;
   reg  [1:0]  nxt_state;
   reg  [15:0] list_addr_ff;
   reg  [15:0] nxt_list_addr;
   reg  [1:0]  list_idx_ff;
   reg  [1:0]  nxt_list_idx;
   reg  [15:0] data_addr_ff;
   reg  [15:0] nxt_data_addr;
   reg  [15:0] count_ff;
   reg  [15:0] nxt_count;
   reg         chain_ff;
   reg         nxt_chain;
   reg  [15:0] next_list_ff;
   reg  [15:0] nxt_next_list;
   reg  [15:0] word_ff;
   reg  [15:0] nxt_word;
   reg         half_ff;
   reg         nxt_half;
   reg  [6:0]  char_ff;
   reg  [6:0]  nxt_char;
   reg         strobe_ff;
   reg         nxt_strobe;
   reg         demand_q_ff;

   // status store side
   reg         stat_pend_ff;
   reg         irq_ff;
   reg  [15:0] stat_word_ff;

   // status event raised by the sequencer this cycle
   // both are combinational and stand for a single cycle only
   reg         done_evt;
   reg         nrdy_evt;

   wire        chan_hit;
   wire        busy;
   wire        accept;
   wire        busy_evt;
   wire        stat_evt;
   wire [15:0] evt_word;
   wire        stat_go;
   wire        rd_req;
   wire        rd_gnt;
   wire        stat_gnt;
   wire        demand_rise;
   wire [15:0] stat_addr;
   wire [15:0] rd_addr;

   // channel decode of activate word 1; the channel is a parameter, not a
   // switch port, so another channel means another build
   assign chan_hit = act_stb_i &&                              // see RQ1
      (act_word1_i[`PDC_ACT_CHAN_HI:`PDC_ACT_CHAN_LO] ==
       CHAN_ADDR);                                             // see RQ2
   assign busy     = (state_ff != ST_IDLE);
   assign accept   = chan_hit && !busy;
   // a second activate while a list runs is reported, not obeyed
   assign busy_evt = chan_hit && busy;                         // see RQ8

   // printer demand is taken on its rising edge so one request gets one char
   // an edge that arrives while a word is fetched is not remembered
   assign demand_rise = prn_demand_i && !demand_q_ff;          // see RQ12

   // the store is held off while the interrupt waits for acknowledge; with
   // interrupts not allowed irq never rises, so the store starts at once
   assign stat_go  = stat_pend_ff && !irq_ff;          // see RQ18 RQ19
   // reads are asked for only while list or data words are fetched
   assign rd_req   = (state_ff == ST_LIST) || (state_ff == ST_READ);
   // status store owns the port whenever it is pending and irq is low
   assign stat_gnt = mem_gnt_i && stat_go;                      // see RQ20
   assign rd_gnt   = mem_gnt_i && !stat_go && rd_req;           // see RQ20

   // reserved pair for this channel; word 1 at the even address, the odd
   // word of the pair is never written since only one word is stored
   assign stat_addr = `PDC_STAT_BASE +
                      {12'h000, CHAN_ADDR, 1'b0};      // see RQ16 RQ17
   assign rd_addr   = (state_ff == ST_LIST) ?
                      (list_addr_ff + {14'h0000, list_idx_ff}) :
                      data_addr_ff;

   // memory port mux; the request may change until it is granted
   // write data is registered, request and address decode from state
   assign mem_req_o   = stat_go || rd_req;
   assign mem_we_o    = stat_go;
   assign mem_addr_o  = stat_go ? stat_addr : rd_addr;
   assign mem_wdata_o = stat_word_ff;

   // status event word: unassigned bits stay zero
   assign stat_evt = busy_evt || done_evt;
   assign evt_word = {12'h000, busy_evt, 1'b0,
                      nrdy_evt || !prn_ready_i, done_evt}; // see RQ9 RQ10 RQ11

   assign irq_o        = irq_ff;
   assign prn_data_o   = char_ff;
   assign prn_strobe_o = strobe_ff;
   assign busy_o       = busy;

   // main sequencer: list fetch, data read, character send
   always @*
   begin
      nxt_state     = state_ff;
      nxt_list_addr = list_addr_ff;
      nxt_list_idx  = list_idx_ff;
      nxt_data_addr = data_addr_ff;
      nxt_count     = count_ff;
      nxt_chain     = chain_ff;
      nxt_next_list = next_list_ff;
      nxt_word      = word_ff;
      nxt_half      = half_ff;
      nxt_char      = char_ff;
      nxt_strobe    = 1'b0;
      done_evt      = 1'b0;
      nrdy_evt      = 1'b0;
      case (state_ff)
         ST_IDLE:
         begin
            if (accept)
            begin
               if (!prn_ready_i)
               begin
                  // printer not ready: abort at once with status
                  done_evt = 1'b1;                              // see RQ10
                  nrdy_evt = 1'b1;                              // see RQ9
               end
               else
               begin
                  nxt_list_addr = act_word2_i;                  // see RQ3
                  nxt_list_idx  = `PDC_LW_DATA;
                  nxt_state     = ST_LIST;
               end
            end
         end
         ST_LIST:
         begin
            // list words come back in order; the index wraps after the last
            if (rd_gnt)
            begin
               case (list_idx_ff)
                  `PDC_LW_DATA:  nxt_data_addr = mem_rdata_i;   // see RQ4
                  `PDC_LW_COUNT: nxt_count     = mem_rdata_i;   // see RQ5
                  `PDC_LW_CTRL:                                 // see RQ6
                     nxt_chain = mem_rdata_i[`PDC_LW3_CHAIN];
                  default:       nxt_next_list = mem_rdata_i;   // see RQ7
               endcase
               nxt_list_idx = list_idx_ff + 2'h1;
               // exactly four words, then data transfer starts
               if (list_idx_ff == `PDC_LIST_LAST)
               begin
                  nxt_state = ST_READ;                          // see RQ3
               end
            end
         end
         ST_READ:
         begin
            // demand edges seen here are lost, so the printer must drop its
            // demand and raise it again once the word has been read
            if (rd_gnt)
            begin
               nxt_word      = mem_rdata_i;
               nxt_data_addr = data_addr_ff + 16'h0001;         // see RQ4
               nxt_half      = 1'b0;
               nxt_state     = ST_SEND;
            end
         end
         ST_SEND:
         begin
            if (!prn_ready_i)
            begin
               // printer dropped out mid list: abort the whole chain
               done_evt  = 1'b1;                                // see RQ10
               nrdy_evt  = 1'b1;                                // see RQ9
               nxt_state = ST_IDLE;
            end
            else if (demand_rise)
            begin
               // codes go out raw, no translation table
               nxt_char   = half_ff ?                           // see RQ15
                            word_ff[`PDC_CH2_HI:`PDC_CH2_LO] :  // see RQ13
                            word_ff[`PDC_CH1_HI:`PDC_CH1_LO];
               nxt_strobe = 1'b1;                               // see RQ12
               nxt_count  = count_ff - 16'h0001;
               nxt_half   = 1'b1;
               if (count_ff == 16'h0001)
               begin
                  // last char; an odd count never reaches bits 9-15
                  if (chain_ff)
                  begin
                     nxt_list_addr = next_list_ff;              // see RQ6
                     nxt_list_idx  = `PDC_LW_DATA;
                     nxt_state     = ST_LIST;
                  end
                  else
                  begin
                     done_evt  = 1'b1;                          // see RQ10 RQ14
                     nxt_state = ST_IDLE;
                  end
               end
               else if (half_ff)
               begin
                  nxt_state = ST_READ;
               end
            end
         end
         default:
         begin
            nxt_state = ST_IDLE;
         end
      endcase
   end

   // sequencer registers
   // every register has a reset value so the port is quiet after reset
   always @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         state_ff     <= ST_IDLE;
         list_addr_ff <= 16'h0000;
         list_idx_ff  <= 2'h0;
         data_addr_ff <= 16'h0000;
         count_ff     <= 16'h0000;
         chain_ff     <= 1'b0;
         next_list_ff <= 16'h0000;
         word_ff      <= 16'h0000;
         half_ff      <= 1'b0;
         char_ff      <= 7'h00;
         strobe_ff    <= 1'b0;
         demand_q_ff  <= 1'b0;
      end
      else
      begin
         state_ff     <= nxt_state;
         list_addr_ff <= nxt_list_addr;
         list_idx_ff  <= nxt_list_idx;
         data_addr_ff <= nxt_data_addr;
         count_ff     <= nxt_count;
         chain_ff     <= nxt_chain;
         next_list_ff <= nxt_next_list;
         word_ff      <= nxt_word;
         half_ff      <= nxt_half;
         char_ff      <= nxt_char;
         strobe_ff    <= nxt_strobe;
         demand_q_ff  <= prn_demand_i;
      end
   end

   // status store and interrupt handshake; a new event merges its bits into
   // a word still waiting, and a set always beats the clear by the grant
   always @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         stat_pend_ff <= 1'b0;
         irq_ff       <= 1'b0;
         stat_word_ff <= 16'h0000;
      end
      else
      begin
         if (stat_evt)
         begin
            stat_pend_ff <= 1'b1;
            stat_word_ff <= (stat_pend_ff && !stat_gnt) ?
                            (stat_word_ff | evt_word) : evt_word;
         end
         else if (stat_gnt)
         begin
            stat_pend_ff <= 1'b0;
         end
         // interrupt raised on the event, dropped by acknowledge
         // a word already waiting on irq is not raised a second time
         if (stat_evt && !interrupt_allow_n_i && !(stat_pend_ff && irq_ff))
         begin
            irq_ff <= 1'b1;                                     // see RQ18
         end
         else if (iack_i)
         begin
            irq_ff <= 1'b0;                                     // see RQ18 RQ21
         end
      end
   end

endmodule // pdc_printer_dma

// File: hw/pdc_defs.vh
`ifndef PDC_DEFS_VH
`define PDC_DEFS_VH

// word bits are numbered with bit 0 as the msb, so field n sits at [15-n]

// activate word 1: channel address field, bits 13 to 15
`define PDC_ACT_CHAN_HI     2
`define PDC_ACT_CHAN_LO     0
// factory channel for the printer controller
`define PDC_DEF_CHAN        3'h5

// list word 3: chain flag, bit 2
`define PDC_LW3_CHAIN       13

// data word: first character bits 1..7, second character bits 9..15
`define PDC_CH1_HI          14
`define PDC_CH1_LO          8
`define PDC_CH2_HI          6
`define PDC_CH2_LO          0

// status word fields: busy bit 12, not ready bit 14, complete bit 15
`define PDC_ST_BUSY         3
`define PDC_ST_NRDY         1
`define PDC_ST_DONE         0

// reserved status pairs: channel 0 at 98/99, two words per channel
`define PDC_STAT_BASE       16'h0098

// list length and list word indices
`define PDC_LIST_LAST       2'h3
`define PDC_LW_DATA         2'h0
`define PDC_LW_COUNT        2'h1
`define PDC_LW_CTRL         2'h2
`define PDC_LW_NEXT         2'h3

`endif

// File: verification/pdc_far_model.sv
`timescale 1ns/10ps
// memory port and line printer as the controller sees them
module pdc_far_model
(
   // memory port
   input  wire logic        clk_i,
   input  wire logic        req_i,
   input  wire logic        we_i,
   input  wire logic [15:0] addr_i,
   input  wire logic [15:0] wdata_i,
   output logic             gnt_o,
   output logic      [15:0] rdata_o,
   // printer
   input  wire logic        strobe_i,
   input  wire logic [6:0]  char_i,
   output logic             demand_o
);
   logic [15:0] mem [0:1023];
   logic [15:0] st_q[$];
   logic [15:0] st_adr;
   logic [6:0]  chr_q[$];
   logic [2:0]  dcnt;
   integer      seed = 15731;
   initial
   begin
      gnt_o = 1'b0;
      rdata_o = 16'h0000;
      demand_o = 1'b0;
      dcnt = 3'h0;
   end
   // random stall before a one-cycle grant; an idle bus inverts the read data every cycle
   always @(negedge clk_i)
   begin
      if (req_i && !gnt_o && ($random(seed) & 1))
      begin
         gnt_o <= 1'b1;
         rdata_o <= mem[addr_i[9:0]];
      end
      else
      begin
         gnt_o <= 1'b0;
         rdata_o <= ~rdata_o;
      end
      // demand drops after each character and now and then, so a
      // rising edge lost while words are fetched is offered again
      dcnt <= dcnt + 3'h1;
      demand_o <= (dcnt != 3'h0) && !strobe_i;
   end
   // log stored status words and printed characters
   always @(posedge clk_i)
   begin
      if (req_i && gnt_o && we_i)
      begin
         st_q.push_back(wdata_i);
         st_adr <= addr_i;
      end
      if (strobe_i)
         chr_q.push_back(char_i);
   end
endmodule // pdc_far_model

// File: verification/pdc_printer_dma_sva.sv
`timescale 1ns/10ps
module pdc_printer_dma_sva
#(parameter [2:0] CHAN_ADDR = 3'h5)
(
   // clock, reset and inputs
   input wire logic        clk_i,
   input wire logic        nrst_i,
   input wire logic        act_stb_i,
   input wire logic [15:0] act_word1_i,
   input wire logic        prn_ready_i,
   input wire logic        prn_demand_i,
   input wire logic        interrupt_allow_n_i,
   input wire logic        iack_i,
   // outputs
   input wire logic        busy_o,
   input wire logic        irq_o,
   input wire logic        mem_req_o,
   input wire logic        mem_we_o,
   input wire logic [15:0] mem_addr_o,
   input wire logic [15:0] mem_wdata_o,
   input wire logic        prn_strobe_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   // command hit and pending status store
   wire hit = act_stb_i && (act_word1_i[2:0] == CHAN_ADDR);
   wire st_wr = mem_req_o && mem_we_o;
   sequence dem_rise;
      !prn_demand_i ##1 prn_demand_i;
   endsequence
   sequence ack_taken;
      irq_o && iack_i;
   endsequence
   chan_skip_a: assert property (
      act_stb_i && !hit && !busy_o |=> !busy_o)
      else $error("foreign activate started a list");
   list_start_a: assert property (
      hit && !busy_o && prn_ready_i && !irq_o && !st_wr
      |=> busy_o && mem_req_o && !mem_we_o)
      else $error("no list read");
   // a word already held by the interrupt cannot be stored at once
   busy_stat_a: assert property (
      hit && busy_o && interrupt_allow_n_i && !irq_o
      |=> st_wr && mem_wdata_o[3])
      else $error("busy status missing");
   nrdy_bit_a: assert property (
      st_wr && !prn_ready_i |-> mem_wdata_o[1])
      else $error("not ready bit missing");
   st_addr_a: assert property (
      st_wr |-> mem_addr_o == 16'h0098 + {12'h000, CHAN_ADDR, 1'b0})
      else $error("status stored at wrong address");
   st_zero_a: assert property (
      st_wr |-> (mem_wdata_o & 16'hFFF4) == 16'h0000)
      else $error("unassigned status bits set");
   hold_off_a: assert property (irq_o |-> !st_wr)
      else $error("status stored before acknowledge");
   ack_store_a: assert property (
      ack_taken |=> !irq_o && st_wr)
      else $error("acknowledge did not start store");
   no_irq_a: assert property (
      interrupt_allow_n_i && $past(interrupt_allow_n_i) |-> !$rose(irq_o))
      else $error("interrupt while not allowed");
   strobe_demand_a: assert property (
      prn_strobe_o |-> ($past(prn_demand_i) && !$past(prn_demand_i, 2))
      ##1 !prn_strobe_o)
      else $error("strobe without demand");
   dem_c: cover property (dem_rise ##1 prn_strobe_o);
endmodule // pdc_printer_dma_sva

// File: verification/pdc_printer_dma_test.sv
`timescale 1ns/10ps
module pdc_printer_dma_test;
   logic        clk_i = 1'b0;
   logic        nrst_i = 1'b0;
   logic        act_stb_i = 1'b0;
   logic        interrupt_allow_n_i = 1'b1;
   logic        iack_i = 1'b0;
   logic        prn_ready_i = 1'b1;
   logic [15:0] act_word1_i = 16'h0000;
   logic [15:0] act_word2_i = 16'h0000;
   wire         irq_o, mem_req_o, mem_we_o, mem_gnt_i;
   wire         prn_demand_i, prn_strobe_o, busy_o;
   wire  [15:0] mem_addr_o, mem_wdata_o, mem_rdata_i;
   wire  [6:0]  prn_data_o;
   integer      err_total = 0;
   integer      num_checks = 0;
   integer      seed = 15731;
   integer      i;
   logic [6:0]  exp_q[$];
   pdc_printer_dma dut
   (
      .clk_i(clk_i), .nrst_i(nrst_i), .act_stb_i(act_stb_i),
      .act_word1_i(act_word1_i), .act_word2_i(act_word2_i),
      .interrupt_allow_n_i(interrupt_allow_n_i), .iack_i(iack_i),
      .irq_o(irq_o), .mem_req_o(mem_req_o), .mem_we_o(mem_we_o),
      .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o),
      .mem_gnt_i(mem_gnt_i), .mem_rdata_i(mem_rdata_i),
      .prn_ready_i(prn_ready_i), .prn_demand_i(prn_demand_i),
      .prn_data_o(prn_data_o), .prn_strobe_o(prn_strobe_o), .busy_o(busy_o)
   );
   pdc_far_model far
   (
      .clk_i(clk_i), .req_i(mem_req_o), .we_i(mem_we_o), .addr_i(mem_addr_o),
      .wdata_i(mem_wdata_o), .gnt_o(mem_gnt_i), .rdata_o(mem_rdata_i),
      .strobe_i(prn_strobe_o), .char_i(prn_data_o), .demand_o(prn_demand_i)
   );
   // 100 ns clock
   initial
   begin
      forever #50 clk_i = ~clk_i;
   end
   task automatic check(input string what, input logic [15:0] exp, got);
      num_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask
   task give_verdict;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // first character sits high in the word, second low
   function automatic logic [6:0] char_at(input logic [15:0] w, input bit sec);
      return sec ? w[6:0] : w[14:8];
   endfunction
   // count is never zero, so the bench only builds lists of 1 or more
   task automatic load_list(input logic [15:0] la, da, cnt, ctl, nxt);
      logic [15:0] w;
      far.mem[la] = da;
      far.mem[la + 16'h1] = cnt;
      far.mem[la + 16'h2] = ctl;
      far.mem[la + 16'h3] = nxt;
      for (int k = 0; k < cnt; k += 2)
      begin
         w = 16'($random(seed));
         far.mem[da + 16'(k / 2)] = w;
         exp_q.push_back(char_at(w, 0));
         if (k + 1 < cnt)
            exp_q.push_back(char_at(w, 1));
      end
   endtask
   task activate(input logic [2:0] ch, input logic [15:0] la);
      @(negedge clk_i);
      act_stb_i = 1'b1;
      act_word1_i = {13'($random(seed)), ch};
      act_word2_i = la;
      @(negedge clk_i);
      act_stb_i = 1'b0;
   endtask
   task wait_st(input integer n);
      for (i = 0; i < 4000 && far.st_q.size() < n; i++)
         @(negedge clk_i);
      if (far.st_q.size() < n)
      begin
         err_total++;
         $display("unexpected status count: expected %0d seen %0d", n,
                  far.st_q.size());
         give_verdict;
      end
   endtask
   task check_chars;
      check("chars", 16'(exp_q.size()), 16'(far.chr_q.size()));
      foreach (exp_q[k])
         if (k < far.chr_q.size())
            check("char", {9'h000, exp_q[k]}, {9'h000, far.chr_q[k]});
      exp_q.delete();
      far.chr_q.delete();
   endtask
   initial
   begin
      repeat (12) @(posedge clk_i);
      @(negedge clk_i);
      nrst_i = 1'b1;
      // foreign channels start nothing
      for (int c = 0; c < 8; c++)
         if (c != 5)
         begin
            activate(3'(c), 16'h0100);
            check("busy", 16'h0000, {15'h0000, busy_o});
         end
      // chained lists, odd count first, then a repeated activate
      load_list(16'h0100, 16'h0200, 16'h0003, 16'h2000, 16'h0110);
      load_list(16'h0110, 16'h0300, 16'h0002, 16'h0000, 16'h0120);
      activate(3'h5, 16'h0100);
      check("busy", 16'h0001, {15'h0000, busy_o});
      activate(3'h5, 16'h0040);
      wait_st(1);
      check("busy status", 16'h0008, far.st_q[0]);
      wait_st(2);
      check("done status", 16'h0001, far.st_q[1]);
      check("status addr", 16'h00A2, far.st_adr);
      check_chars;
      // store held back until the host acknowledges
      interrupt_allow_n_i = 1'b0;
      load_list(16'h0140, 16'h0380, 16'h0001, 16'h0000, 16'h0000);
      activate(3'h5, 16'h0140);
      for (i = 0; i < 4000 && irq_o !== 1'b1; i++)
         @(negedge clk_i);
      if (irq_o !== 1'b1)
      begin
         err_total++;
         $display("unexpected irq: expected 1 seen %b", irq_o);
         give_verdict;
      end
      repeat (4) @(negedge clk_i);
      check("irq", 16'h0001, {15'h0000, irq_o});
      check("held", 16'h0002, 16'(far.st_q.size()));
      iack_i = 1'b1;
      @(negedge clk_i);
      iack_i = 1'b0;
      wait_st(3);
      check("irq status", 16'h0001, far.st_q[2]);
      check_chars;
      // printer not ready
      interrupt_allow_n_i = 1'b1;
      prn_ready_i = 1'b0;
      activate(3'h5, 16'h0100);
      wait_st(4);
      check("nrdy status", 16'h0003, far.st_q[3]);
      prn_ready_i = 1'b1;
      // printer drops out mid list: the chain back to itself is cut
      load_list(16'h0180, 16'h0390, 16'h0006, 16'h2000, 16'h0180);
      activate(3'h5, 16'h0180);
      for (i = 0; i < 4000 && far.chr_q.size() == 0; i++)
         @(negedge clk_i);
      if (far.chr_q.size() == 0)
      begin
         err_total++;
         $display("unexpected first char: expected 1 seen 0");
         give_verdict;
      end
      prn_ready_i = 1'b0;
      wait_st(5);
      check("cut status", 16'h0003, far.st_q[4]);
      check("cut busy", 16'h0000, {15'h0000, busy_o});
      check("cut short", 16'h0001,
            {15'h0000, far.chr_q.size() < exp_q.size()});
      foreach (far.chr_q[k])
         check("cut char", {9'h000, exp_q[k]},
               {9'h000, far.chr_q[k]});
      exp_q.delete();
      far.chr_q.delete();
      prn_ready_i = 1'b1;
      give_verdict;
   end
endmodule // pdc_printer_dma_test
bind pdc_printer_dma pdc_printer_dma_sva #(.CHAN_ADDR(CHAN_ADDR)) sva
(
   .clk_i(clk_i), .nrst_i(nrst_i), .act_stb_i(act_stb_i),
   .act_word1_i(act_word1_i), .prn_ready_i(prn_ready_i),
   .prn_demand_i(prn_demand_i), .interrupt_allow_n_i(interrupt_allow_n_i),
   .iack_i(iack_i), .busy_o(busy_o), .irq_o(irq_o), .mem_req_o(mem_req_o),
   .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o),
   .prn_strobe_o(prn_strobe_o)
);
